// ===== core/intc_pkg.sv
// Purpose: shared constants for the master-mode interrupt service logic
// Assumes: registers are 16 bits wide in the low half of a 32-bit APB word, except the 30-bit priority register
// Notes:   printed offsets are register indexes; byte address is index * 4
package intc_pkg;

    localparam int          NSRC       = 11;
    typedef logic [NSRC-1:0] src_vec_t;
    typedef logic [29:0]     prio_vec_t;

    // register indexes and their APB byte addresses
    localparam logic [7:0]  IDX_EOI    = 8'h22;
    localparam logic [7:0]  IDX_POLL   = 8'h24;
    localparam logic [7:0]  IDX_PASSIVE_POLL_STATUS = 8'h26;
    localparam logic [7:0]  IDX_MASK   = 8'h28;
    localparam logic [7:0]  IDX_THR    = 8'h2A;
    localparam logic [7:0]  IDX_SERV   = 8'h2C;
    localparam logic [7:0]  IDX_PRIO   = 8'h40;
    localparam logic [7:0]  IDX_MODE   = 8'h42;
    localparam logic [9:0]  ADDR_EOI    = {IDX_EOI, 2'b00};
    localparam logic [9:0]  ADDR_POLL   = {IDX_POLL, 2'b00};
    localparam logic [9:0]  ADDR_PASSIVE_POLL_STATUS = {IDX_PASSIVE_POLL_STATUS, 2'b00};
    localparam logic [9:0]  ADDR_MASK   = {IDX_MASK, 2'b00};
    localparam logic [9:0]  ADDR_THR    = {IDX_THR, 2'b00};
    localparam logic [9:0]  ADDR_SERV   = {IDX_SERV, 2'b00};
    localparam logic [9:0]  ADDR_PRIO   = {IDX_PRIO, 2'b00};
    localparam logic [9:0]  ADDR_MODE   = {IDX_MODE, 2'b00};

    // source bit positions
    localparam int          BIT_TMR    = 0;
    localparam int          BIT_DMA0   = 2;
    localparam int          BIT_DMA1   = 3;
    localparam int          BIT_EXT0   = 4;
    localparam int          BIT_EXT4   = 8;
    localparam int          BIT_WD     = 9;
    localparam int          BIT_SER    = 10;
    localparam src_vec_t    NEST_BITS  = 11'h030;

    // field positions
    localparam int          PEND_BIT   = 15;
    localparam int          NONSPECIFIC_FLAG_BIT  = 15;
    localparam int          PRIO_W     = 3;
    localparam int          SFNM_BIT   = 0;

    // reset values
    localparam logic [15:0] MASK_RST   = 16'h07FD;
    localparam logic [15:0] THR_RST    = 16'h0007;
    localparam logic [15:0] SERV_RST   = 16'h0000;
    localparam prio_vec_t   PRIO_RST   = 30'h3FFF_FFFF;

    // interrupt types
    localparam logic [4:0]  TYPE_TMR0  = 5'h08;
    localparam logic [4:0]  TYPE_TMR1  = 5'h12;
    localparam logic [4:0]  TYPE_TMR2  = 5'h13;
    localparam logic [4:0]  TYPE_DMA0  = 5'h0A;
    localparam logic [4:0]  TYPE_DMA1  = 5'h0B;
    localparam logic [4:0]  TYPE_EXT0  = 5'h0C;
    localparam logic [4:0]  TYPE_WD    = 5'h11;
    localparam logic [4:0]  TYPE_SER   = 5'h14;

endpackage

// ===== core/intc_master.sv
// Purpose: master-mode in-service tracking, masking, priority poll and
//          end-of-service commands behind an APB slave
// Assumes: TIMER_REQ, DMA_DONE, WATCHDOG_FIRE, SERIAL_REQ, CORE_ACK are on
//          REF_CLK; EXT_INT comes from pins
// Notes:   zero wait writes and reads (read data is registered in the setup phase)
// Function
// - in-service bit sets on acknowledge, clears on matching end-of-service
// - a source in service raises no new request
// - special nested mode lets first two pins request while in service
// - in-service register resets to zero
// - in-service bits: serial 10, watchdog 9, pins 8-4, DMA 3-2, timer 0
// - sources with priority numerically above threshold are masked
// - threshold sits in bits 2-0 and resets to seven
// - mask register and per-source mask bits are one storage
// - mask bit one blocks its source, zero lets it request
// - mask register resets with all source bits set, bit 1 clear
// - mask register uses in-service bit placement
// - passive poll read returns poll contents without acknowledging
// - poll read acknowledges highest pending and sets its service bit
// - poll words: pending flag bit 15, type bits 4-0, rest zero
// - poll acknowledge starts no handler; software dispatches
// - end-of-service register is write-only command
// - bit 15 set means non-specific, clear means type in bits 4-0
// - fixed interrupt types used in poll and specific commands
// - watchdog and DMA request bits clear on their acknowledge
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
module intc_master
    import intc_pkg::*;
(
    input  wire logic                REF_CLK,
    input  wire logic                SYS_RST,
    input  wire logic                CLK_EN,
    input  wire logic                PSEL,
    input  wire logic                PENABLE,
    input  wire logic                PWRITE,
    input  wire logic [9:0]          PADDR,
    input  wire logic [31:0]         PWDATA,
    input  wire logic [3:0]          PSTRB,
    output logic      [31:0]         PRDATA,
    output logic                     PREADY,
    output logic                     PSLVERR,
    input  wire logic [2:0]          TIMER_REQ,
    input  wire logic [1:0]          DMA_DONE,
    input  wire logic                WATCHDOG_FIRE,
    input  wire logic                SERIAL_REQ,
    input  wire logic [4:0]          EXT_INT,
    input  wire logic                CORE_ACK,
    output logic                     INT_REQ,
    output logic      [4:0]          INT_TYPE,
    output intc_pkg::src_vec_t       SOURCE_MASK,
    output intc_pkg::src_vec_t       SOURCE_ACK
);
    import intc_pkg::*;

    src_vec_t    service_tracking;
    src_vec_t    source_mask_mirror;
    logic [2:0]  threshold_field;
    prio_vec_t   source_priority;
    logic        sfnm;
    logic [4:0]  ext_meta;
    logic [4:0]  ext_sync;
    logic [1:0]  dma_channel_sources;
    logic        watchdog_source;
    src_vec_t    raw_req;
    src_vec_t    eligible;
    logic [4:0]  best;
    logic [4:0]  best_type;
    logic [4:0]  serv_best;
    logic        rd_loaded;
    logic        poll_cap_vld;
    logic [3:0]  poll_cap_idx;
    logic [3:0]  int_idx;
    logic        wr_fire;
    logic        rd_fire;
    logic        poll_fire;
    logic        core_fire;
    logic        mapped;
    src_vec_t    set_vec;
    src_vec_t    clr_vec;
    src_vec_t    next_service;
    logic [15:0] poll_word;
    logic [31:0] read_mux;

    function automatic logic [2:0] prio_of(input prio_vec_t pr,
                                           input int b);
        int k;
        k = (b == 0) ? 0 : b - 1;
        return pr[k*PRIO_W +: PRIO_W];
    endfunction

    function automatic logic [4:0] src_type(input int b,
                                            input logic [2:0] treq);
        logic [4:0] t;
        t = 5'h00;
        case (b)
            BIT_TMR:  t = treq[0] ? TYPE_TMR0 :
                          (treq[1] ? TYPE_TMR1 : TYPE_TMR2);
            BIT_DMA0: t = TYPE_DMA0;
            BIT_DMA1: t = TYPE_DMA1;
            BIT_WD:   t = TYPE_WD;
            BIT_SER:  t = TYPE_SER;
            default: begin
                if (b >= BIT_EXT0 && b <= BIT_EXT4)
                    t = TYPE_EXT0 + 5'(b - BIT_EXT0);
            end
        endcase
        return t;
    endfunction

    // returns {found, index}; lowest priority value wins, then lower type
    function automatic logic [4:0] pick(input src_vec_t v,
                                        input prio_vec_t pr,
                                        input logic [2:0] treq);
        logic       found;
        logic [3:0] idx;
        logic [2:0] bp;
        logic [4:0] bt;
        found = 1'b0;
        idx   = 4'h0;
        bp    = 3'h7;
        bt    = 5'h1F;
        for (int b = 0; b < NSRC; b++) begin
            if (v[b] && (!found || prio_of(pr, b) < bp ||
                (prio_of(pr, b) == bp && src_type(b, treq) < bt))) begin
                found = 1'b1;
                idx   = 4'(b);
                bp    = prio_of(pr, b);
                bt    = src_type(b, treq);
            end
        end
        return {found, idx};
    endfunction

    function automatic src_vec_t type_to_vec(input logic [4:0] t);
        src_vec_t v;
        v = '0;
        if (t == TYPE_TMR0 || t == TYPE_TMR1 || t == TYPE_TMR2)
            v[BIT_TMR] = 1'b1;
        for (int b = BIT_DMA0; b < NSRC; b++) begin
            if (t == src_type(b, 3'b000))
                v[b] = 1'b1;
        end
        return v;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i])
                r[i*8 +: 8] = wd[i*8 +: 8];
        end
        return r;
    endfunction

    // pins pass two flops; only the second is read by logic
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ext_meta <= 5'h00;
            ext_sync <= 5'h00;
        end else if (CLK_EN) begin
            ext_meta <= EXT_INT;
            ext_sync <= ext_meta;
        end
    end

    always_comb begin
        raw_req                        = '0;
        raw_req[BIT_TMR]               = |TIMER_REQ;
        raw_req[BIT_DMA1:BIT_DMA0]     = dma_channel_sources;
        raw_req[BIT_EXT4:BIT_EXT0]     = ext_sync;
        raw_req[BIT_WD]                = watchdog_source;
        raw_req[BIT_SER]               = SERIAL_REQ;
        eligible = '0;
        for (int b = 0; b < NSRC; b++) begin
            eligible[b] = raw_req[b]
                & ~source_mask_mirror[b]
                & (prio_of(source_priority, b) <= threshold_field)
                & (~service_tracking[b]
                   | (sfnm & NEST_BITS[b]));
        end
    end

    assign best      = pick(eligible, source_priority, TIMER_REQ);
    assign best_type = src_type(int'(best[3:0]), TIMER_REQ);
    assign serv_best = pick(service_tracking, source_priority, TIMER_REQ);

    // APB handshake: writes finish at once, reads after data is loaded
    assign PREADY    = CLK_EN & (PWRITE | rd_loaded);
    assign wr_fire   = PSEL & PENABLE & PWRITE & PREADY;
    assign rd_fire   = PSEL & PENABLE & ~PWRITE & PREADY;
    assign poll_fire = rd_fire & (PADDR == ADDR_POLL) & poll_cap_vld;
    assign core_fire = CORE_ACK & INT_REQ & CLK_EN;

    always_comb begin
        case (PADDR)
            ADDR_EOI, ADDR_POLL, ADDR_PASSIVE_POLL_STATUS, ADDR_MASK,
            ADDR_THR, ADDR_SERV, ADDR_PRIO, ADDR_MODE: mapped = 1'b1;
            default:                                   mapped = 1'b0;
        endcase
    end
    assign PSLVERR = PSEL & PENABLE & PREADY & ~mapped;

    assign poll_word = {best[4], 10'h000, best[4] ? best_type : 5'h00};

    always_comb begin
        read_mux = 32'h0000_0000;
        case (PADDR)
            ADDR_POLL, ADDR_PASSIVE_POLL_STATUS: read_mux[15:0] = poll_word;
            ADDR_MASK:  read_mux[NSRC-1:0] = source_mask_mirror;
            ADDR_THR:   read_mux[PRIO_W-1:0] = threshold_field;
            ADDR_SERV:  read_mux[NSRC-1:0] = service_tracking;
            ADDR_PRIO:  read_mux[29:0] = source_priority;
            ADDR_MODE:  read_mux[SFNM_BIT] = sfnm;
            default:    read_mux = 32'h0000_0000;
        endcase
    end

    // read data is frozen at load so poll data and acknowledge agree
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rd_loaded    <= 1'b0;
            PRDATA       <= 32'h0000_0000;
            poll_cap_vld <= 1'b0;
            poll_cap_idx <= 4'h0;
        end else if (CLK_EN) begin
            if (rd_fire) begin
                rd_loaded <= 1'b0;
            end else if (PSEL && !PWRITE && !rd_loaded) begin
                rd_loaded    <= 1'b1;
                PRDATA       <= read_mux;
                poll_cap_vld <= best[4] && (PADDR == ADDR_POLL);
                poll_cap_idx <= best[3:0];
            end
        end
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            INT_REQ  <= 1'b0;
            INT_TYPE <= 5'h00;
            int_idx  <= 4'h0;
        end else if (CLK_EN) begin
            INT_REQ  <= best[4] & ~core_fire;
            INT_TYPE <= best[4] ? best_type : 5'h00;
            int_idx  <= best[3:0];
        end
    end

    // an acknowledge only marks service; no handler is started here
    always_comb begin
        set_vec = '0;
        if (poll_fire)
            set_vec = set_vec | (src_vec_t'(1) << poll_cap_idx);
        if (core_fire)
            set_vec = set_vec | (src_vec_t'(1) << int_idx);
        clr_vec = '0;
        if (wr_fire && PADDR == ADDR_EOI) begin
            if (PWDATA[NONSPECIFIC_FLAG_BIT]) begin
                if (serv_best[4])
                    clr_vec = src_vec_t'(1) << serv_best[3:0];
            end else begin
                clr_vec = type_to_vec(PWDATA[4:0]);
            end
        end
        // an acknowledge in the same cycle as a clear keeps the bit set
        next_service = (service_tracking & ~clr_vec) | set_vec;
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            service_tracking <= SERV_RST[NSRC-1:0];
            SOURCE_ACK       <= '0;
        end else if (CLK_EN) begin
            service_tracking <= next_service;
            SOURCE_ACK       <= set_vec;
        end
    end

    // internal event requests: a new event in the acknowledge cycle wins
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            dma_channel_sources <= 2'b00;
            watchdog_source     <= 1'b0;
        end else if (CLK_EN) begin
            dma_channel_sources <= (dma_channel_sources
                & ~set_vec[BIT_DMA1:BIT_DMA0]) | DMA_DONE;
            watchdog_source <= (watchdog_source & ~set_vec[BIT_WD])
                | WATCHDOG_FIRE;
        end
    end

    // a single mask store feeds both the register and per-source outputs
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            source_mask_mirror <= MASK_RST[NSRC-1:0];
        end else if (CLK_EN && wr_fire && PADDR == ADDR_MASK) begin
            source_mask_mirror <= src_vec_t'(merge(32'(source_mask_mirror),
                PWDATA, PSTRB)) & MASK_RST[NSRC-1:0];
        end
    end
    assign SOURCE_MASK = source_mask_mirror;

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            threshold_field <= THR_RST[PRIO_W-1:0];
        end else if (CLK_EN && wr_fire && PADDR == ADDR_THR && PSTRB[0]) begin
            threshold_field <= PWDATA[PRIO_W-1:0];
        end
    end

    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            source_priority <= PRIO_RST;
            sfnm            <= 1'b0;
        end else if (CLK_EN && wr_fire) begin
            if (PADDR == ADDR_PRIO)
                source_priority <= prio_vec_t'(merge(32'(source_priority),
                    PWDATA, PSTRB));
            if (PADDR == ADDR_MODE && PSTRB[0])
                sfnm <= PWDATA[SFNM_BIT];
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);

    sequence s_poll_taken;
        CLK_EN && poll_fire;
    endsequence

    sequence s_eoi_specific;
        CLK_EN && wr_fire && PADDR == ADDR_EOI && !PWDATA[NONSPECIFIC_FLAG_BIT];
    endsequence

    sequence s_eoi_nonspec;
        CLK_EN && wr_fire && PADDR == ADDR_EOI && PWDATA[NONSPECIFIC_FLAG_BIT];
    endsequence

    a_poll_sets_serv: assert property (
        s_poll_taken |=> service_tracking[$past(poll_cap_idx)])
        else $error("poll acknowledge did not set service bit");

    a_passive_poll: assert property (
        CLK_EN && rd_fire && PADDR == ADDR_PASSIVE_POLL_STATUS && !core_fire
        |=> $stable(service_tracking))
        else $error("passive poll read changed service state");

    a_no_reentry: assert property (
        best[4] |-> !service_tracking[best[3:0]]
                    || (sfnm && NEST_BITS[best[3:0]]))
        else $error("source in service still requesting");

    a_masked_quiet: assert property (
        best[4] |-> !source_mask_mirror[best[3:0]])
        else $error("masked source requesting");

    a_threshold_cut: assert property (
        best[4] |-> prio_of(source_priority, int'(best[3:0]))
                    <= threshold_field)
        else $error("selected source above threshold");

    a_eoi_specific: assert property (
        s_eoi_specific ##0 (set_vec == '0)
        |=> (service_tracking & $past(type_to_vec(PWDATA[4:0]))) == '0)
        else $error("specific end-of-service left bit set");

    a_eoi_nonspec: assert property (
        s_eoi_nonspec ##0 (set_vec == '0) ##0 serv_best[4]
        |=> $countones(service_tracking ^ $past(service_tracking)) == 1)
        else $error("non-specific end-of-service cleared wrong bits");

    a_poll_format: assert property (
        CLK_EN && PSEL && !PWRITE && !rd_loaded && PADDR == ADDR_POLL
        |=> PRDATA[14:5] == 10'h000 && PRDATA[31:16] == 16'h0000)
        else $error("poll word reserved bits not zero");

    a_dma_clear: assert property (
        s_poll_taken ##0 (poll_cap_idx == 4'(BIT_DMA0)) ##0 !DMA_DONE[0]
        |=> !dma_channel_sources[0])
        else $error("DMA request survived its acknowledge");

    a_reset_values: assert property (
        $fell(SYS_RST) |-> source_mask_mirror == MASK_RST[NSRC-1:0]
            && threshold_field == THR_RST[PRIO_W-1:0]
            && service_tracking == '0)
        else $error("wrong reset values");

endmodule

// ===== sim/intc_sources.sv
// Purpose: model of the core and the interrupt sources around the block
// Assumes: every request is launched just after a rising REF_CLK edge
// Notes:   DMA and watchdog give one-cycle pulses, the rest hold levels
`timescale 1ns/10ps
module intc_sources (
    input  wire logic       REF_CLK,
    input  wire logic       INT_REQ,
    output logic [2:0]      TIMER_REQ,
    output logic [1:0]      DMA_DONE,
    output logic            WATCHDOG_FIRE,
    output logic            SERIAL_REQ,
    output logic [4:0]      EXT_INT,
    output logic            CORE_ACK
);
    initial begin
        TIMER_REQ = 3'h0;
        DMA_DONE = 2'h0;
        WATCHDOG_FIRE = 1'b0;
        SERIAL_REQ = 1'b0;
        EXT_INT = 5'h00;
        CORE_ACK = 1'b0;
    end

    task automatic pulse(input int b);
        @(posedge REF_CLK);
        if (b == 9) WATCHDOG_FIRE <= 1'b1;
        else DMA_DONE[b-2] <= 1'b1;
        @(posedge REF_CLK);
        WATCHDOG_FIRE <= 1'b0;
        DMA_DONE <= 2'h0;
    endtask

    // level sources hold until their own unit clears them
    task automatic level(input int b, input logic v);
        @(posedge REF_CLK);
        if (b < 2) TIMER_REQ[b] <= v;
        else if (b == 10) SERIAL_REQ <= v;
        else EXT_INT[b-4] <= v;
    endtask

    // the pulse only takes the interrupt; software runs the handler later
    task automatic ack(output bit ok);
        int i;
        ok = 1'b0;
        for (i = 0; i < 40 && !ok; i++) begin
            @(posedge REF_CLK);
            ok = (INT_REQ === 1'b1);
        end
        if (ok) begin
            CORE_ACK <= 1'b1;
            @(posedge REF_CLK);
            CORE_ACK <= 1'b0;
        end
    endtask
endmodule

// ===== sim/tb_master_mode_interrupt_service_logic.sv
// Purpose: self-checking bench for the master-mode interrupt service logic
// Assumes: APB master changes signals only just after rising edges
// Notes:   random mask, priority and threshold values from a fixed seed
`timescale 1ns/10ps
module tb_master_mode_interrupt_service_logic;
    import intc_pkg::*;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [9:0]  paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd_q, v;
    logic        pready, pslverr, last_err, int_req, core_ack, wd, ser;
    logic [2:0]  timer_req, p, t;
    logic [1:0]  dma_done;
    logic [4:0]  ext_int, int_type;
    src_vec_t    source_mask, source_ack;
    int          n_errors = 0, n_compared = 0, b, k;
    integer      seed = 32'h9d97_1e2f;
    int          srcs[10] = '{0, 2, 3, 4, 5, 6, 7, 8, 9, 10};
    bit          ok;

    always #50 ref_clk = ~ref_clk;

    intc_master dut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .CLK_EN(1'b1),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PSTRB(4'hF), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .TIMER_REQ(timer_req), .DMA_DONE(dma_done),
        .WATCHDOG_FIRE(wd), .SERIAL_REQ(ser), .EXT_INT(ext_int),
        .CORE_ACK(core_ack), .INT_REQ(int_req), .INT_TYPE(int_type),
        .SOURCE_MASK(source_mask), .SOURCE_ACK(source_ack));

    intc_sources u_src (.REF_CLK(ref_clk), .INT_REQ(int_req),
        .TIMER_REQ(timer_req), .DMA_DONE(dma_done), .WATCHDOG_FIRE(wd),
        .SERIAL_REQ(ser), .EXT_INT(ext_int), .CORE_ACK(core_ack));

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [9:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_errors++;
            $display("MISMATCH pready expected 1 seen 0");
            close_out();
        end
        rd_q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input string n, input logic [9:0] a,
                       input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd_q);
    endtask

    task automatic settle();
        repeat (6) @(posedge ref_clk);
    endtask

    task automatic raise(input int s, input logic on);
        if (s == 2 || s == 3 || s == 9) begin
            if (on) u_src.pulse(s);
        end else u_src.level(s, on);
    endtask

    function automatic logic [4:0] exp_type(input int s);
        case (s)
            0: return TYPE_TMR0;
            2: return TYPE_DMA0;
            3: return TYPE_DMA1;
            9: return TYPE_WD;
            10: return TYPE_SER;
            default: return TYPE_EXT0 + 5'(s - 4);
        endcase
    endfunction

    initial begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rdc("mask rst", ADDR_MASK, 32'h0000_07FD);
        rdc("thr rst", ADDR_THR, 32'h7);
        rdc("serv rst", ADDR_SERV, 32'h0);
        rdc("poll rst", ADDR_PASSIVE_POLL_STATUS, 32'h0);
        rdc("eoi read", ADDR_EOI, 32'h0);
        wr(ADDR_SERV, 32'h0000_07FF);
        rdc("serv ro", ADDR_SERV, 32'h0);
        rdc("unmapped", 10'h3FC, 32'h0);
        chk("slverr", 32'h1, {31'h0, last_err});
        v = $random(seed);
        wr(ADDR_MASK, v);
        rdc("mask rw", ADDR_MASK, v & 32'h0000_07FD);
        chk("mask mirror", v & 32'h0000_07FD, {21'h0, source_mask});
        $display("test registers done");
        foreach (srcs[i]) begin
            b = srcs[i];
            wr(ADDR_MASK, 32'h0000_07FD);
            raise(b, 1'b1);
            settle();
            rdc("masked", ADDR_PASSIVE_POLL_STATUS, 32'h0);
            wr(ADDR_MASK, 32'h0000_07FD & ~(32'h0000_0001 << b));
            settle();
            v = {16'h0, 16'h8000 | 16'(exp_type(b))};
            rdc("passive_poll_status", ADDR_PASSIVE_POLL_STATUS, v);
            rdc("passive_poll_status again", ADDR_PASSIVE_POLL_STATUS, v);
            chk("int req", 32'h1, 32'(int_req));
            chk("int type", 32'(exp_type(b)), 32'(int_type));
            rdc("poll", ADDR_POLL, v);
            @(negedge ref_clk);
            chk("ack pulse", 32'h1 << b, 32'(source_ack));
            settle();
            rdc("service_tracking", ADDR_SERV, 32'h0000_0001 << b);
            rdc("no reentry", ADDR_PASSIVE_POLL_STATUS, 32'h0);
            raise(b, 1'b0);
            wr(ADDR_EOI, {27'h0, (b == 0) ? TYPE_TMR2 : exp_type(b)});
            settle();
            rdc("eoi specific", ADDR_SERV, 32'h0);
            rdc("req cleared", ADDR_PASSIVE_POLL_STATUS, 32'h0);
        end
        $display("test sources done");
        for (k = 0; k < 10; k++) begin
            p = (k == 0) ? 3'h5 : 3'($random(seed));
            t = (k == 0) ? 3'h4 : 3'($random(seed));
            wr(ADDR_PRIO, {2'h0, 24'hFF_FFFF, p, 3'h7});
            wr(ADDR_THR, {29'h0, t});
            rdc("thr rw", ADDR_THR, {29'h0, t});
            wr(ADDR_MASK, 32'h0000_07F9);
            raise(2, 1'b1);
            settle();
            rdc("thresh", ADDR_PASSIVE_POLL_STATUS, (p <= t) ? 32'h0000_800A : 32'h0);
            wr(ADDR_THR, 32'h7);
            rdc("ack", ADDR_POLL, 32'h0000_800A);
            wr(ADDR_EOI, 32'h0000_000A);
        end
        $display("test threshold done");
        wr(ADDR_PRIO, {2'h0, PRIO_RST});
        wr(ADDR_MASK, 32'h0000_07F1);
        raise(3, 1'b1);
        raise(2, 1'b1);
        settle();
        rdc("tie", ADDR_PASSIVE_POLL_STATUS, 32'h0000_800A);
        wr(ADDR_PRIO, {2'h0, 21'h1F_FFFF, 3'h0, 6'h3F});
        settle();
        rdc("prio order", ADDR_PASSIVE_POLL_STATUS, 32'h0000_800B);
        rdc("poll first", ADDR_POLL, 32'h0000_800B);
        rdc("poll next", ADDR_POLL, 32'h0000_800A);
        rdc("both serv", ADDR_SERV, 32'h0000_000C);
        wr(ADDR_EOI, 32'h0000_8000);
        rdc("nonspecific", ADDR_SERV, 32'h0000_0004);
        wr(ADDR_EOI, 32'h0000_000A);
        rdc("specific", ADDR_SERV, 32'h0);
        $display("test nesting order done");
        wr(ADDR_PRIO, {2'h0, PRIO_RST});
        wr(ADDR_MASK, 32'h0000_07ED);
        wr(ADDR_MODE, 32'h1);
        raise(4, 1'b1);
        settle();
        rdc("pin poll", ADDR_POLL, 32'h0000_800C);
        settle();
        rdc("nested", ADDR_PASSIVE_POLL_STATUS, 32'h0000_800C);
        wr(ADDR_MODE, 32'h0);
        settle();
        rdc("not nested", ADDR_PASSIVE_POLL_STATUS, 32'h0);
        raise(4, 1'b0);
        wr(ADDR_EOI, 32'h0000_000C);
        $display("test special nesting done");
        wr(ADDR_MASK, 32'h0000_03FD);
        raise(10, 1'b1);
        u_src.ack(ok);
        chk("core ack seen", 32'h1, {31'h0, ok});
        settle();
        rdc("core serv", ADDR_SERV, 32'h0000_0400);
        raise(10, 1'b0);
        wr(ADDR_EOI, 32'h0000_8000);
        rdc("core eoi", ADDR_SERV, 32'h0);
        wr(ADDR_MASK, 32'h0000_07FC);
        u_src.level(1, 1'b1);
        settle();
        rdc("timer1", ADDR_POLL, 32'h0000_8000 | 32'(TYPE_TMR1));
        u_src.level(1, 1'b0);
        wr(ADDR_EOI, {27'h0, TYPE_TMR1});
        rdc("timer1 eoi", ADDR_SERV, 32'h0);
        $display("test core acknowledge done");
        close_out();
    end
endmodule
